// File: core/opaf_map.svh
// Constants for the operand address and compare flag logic.
// Assumes inclusion by bare name from the package, the address unit and the core module.
//
// How it works
// - Addition never touches the compare flag
// - Equal-immediate compare sets flag when index_register_zero matches
// - Signed not-less compare; branches test flag set/clear
// - Byte immediates come straight from instruction field
// - No word or longword immediates in encodings
// - Literal loads use pc_relative_literal addressing
// - Absolute access: literal load, then register indirect
// - Wide displacement: literal into index_register_zero, then indexed
// - Register direct: operand is register, no memory
// - Register indirect address equals register, unmodified
// - Post-increment: old address, then add 1/2/4
// - Pre-decrement: subtract 1/2/4, use and write back
// - Byte and word loads sign-extended to 32 bits
// - Misaligned word or longword raises address error
// - Longword literal masks low PC bits, scales by four
`ifndef OPAF_MAP_SVH
`define OPAF_MAP_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define OPAF_DATA_W   32
`define OPAF_IMM_W    8
`define OPAF_RIDX_W   4

// ----------------------------------------------------------------
// Auto-modify steps per operand size
// ----------------------------------------------------------------
`define OPAF_STEP_BYTE 32'h00000001
`define OPAF_STEP_WORD 32'h00000002
`define OPAF_STEP_LONG 32'h00000004

// ----------------------------------------------------------------
// Masks and reset values
// ----------------------------------------------------------------
`define OPAF_PC_LONG_MASK 32'hFFFFFFFC
`define OPAF_FLAG_RST     1'b0

`endif

// File: core/opaf_pkg.sv
// Types shared by the operand address and compare flag logic.
// Assumes opaf_map.svh is on the include path.
`include "opaf_map.svh"

package opaf_pkg;

	// ----------------------------------------------------------------
	// Operation classes handed over by the decoder
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_NONE, OP_ADD_REG, OP_ADD_IMM, OP_COMPARE_EQUAL_IMM,
		OP_COMPARE_SIGNED_NOT_LESS, OP_BR_SET, OP_BR_CLR, OP_MEM
	} opaf_op_t;

	// Addressing modes served here
	typedef enum logic [2:0] {
		AM_DIRECT, AM_INDIRECT, AM_POSTINC, AM_PREDEC, AM_INDEXED, AM_PCREL
	} opaf_mode_t;

	// Operand sizes
	typedef enum logic [1:0] {
		SZ_BYTE, SZ_WORD, SZ_LONG
	} opaf_size_t;

	// Core sequencer states
	typedef enum logic {
		ST_IDLE, ST_WAIT
	} opaf_state_t;

	// Step for auto-modify modes, decoded in several places
	function automatic logic [31:0] opaf_step(input opaf_size_t sz);
		opaf_step = (sz == SZ_BYTE) ? `OPAF_STEP_BYTE :
		            (sz == SZ_WORD) ? `OPAF_STEP_WORD : `OPAF_STEP_LONG;
	endfunction

	// Sign extension of memory data to register width
	function automatic logic [31:0] opaf_sext(input logic [31:0] d, input opaf_size_t sz);
		opaf_sext = (sz == SZ_BYTE) ? {{24{d[7]}}, d[7:0]} :
		            (sz == SZ_WORD) ? {{16{d[15]}}, d[15:0]} : d;
	endfunction

endpackage

// File: core/opaf_ea_if.sv
// Carrier between the core sequencer and the effective address unit.
// Assumes one clock domain; purely combinational signals.
`timescale 1ns/1ps
`default_nettype none

interface opaf_ea_if;
	import opaf_pkg::*;
	opaf_mode_t  mode;     // Addressing mode
	opaf_size_t  size;     // Operand size
	logic [31:0] rn;       // Selected general register value
	logic [31:0] r0;       // Index register zero value
	logic [31:0] pc;       // Program counter of the instruction
	logic [7:0]  disp;     // Instruction displacement field
	logic [31:0] addr;     // Effective address
	logic [31:0] new_rn;   // Auto-modified register value
	logic        wr_rn;    // Register is auto-modified
	logic        misalign; // Address error condition
	logic        uses_mem; // Mode performs a memory access

	modport req  (output mode, size, rn, r0, pc, disp, input addr, new_rn, wr_rn, misalign, uses_mem);
	modport unit (input mode, size, rn, r0, pc, disp, output addr, new_rn, wr_rn, misalign, uses_mem);
endinterface

`default_nettype wire

// File: core/opaf_ea.sv
// Effective address unit: forms the access address and auto-modify value.
// Assumes register values are stable during the issue cycle.
`timescale 1ns/1ps
`default_nettype none
`include "opaf_map.svh"

module opaf_ea
	import opaf_pkg::*;
(
	// Request from the sequencer
	opaf_ea_if.unit ea
);

	logic [31:0] step;   // Size-dependent step
	logic [31:0] scaled; // Zero-extended displacement times size

	// ----------------------------------------------------------------
	// Address formation
	// ----------------------------------------------------------------
	always_comb
	begin
		step   = opaf_step(ea.size);
		scaled = {24'h000000, ea.disp};
		if (ea.size == SZ_WORD)
			scaled = {23'h0, ea.disp, 1'b0};
		else if (ea.size == SZ_LONG)
			scaled = {22'h0, ea.disp, 2'b00};
		ea.new_rn   = ea.rn;
		ea.wr_rn    = 1'b0;
		ea.uses_mem = 1'b1;
		unique case (ea.mode)
			// Operand is the register itself
			AM_DIRECT:
			begin
				ea.addr     = ea.rn;
				ea.uses_mem = 1'b0;
			end
			// Register value as is; also the second step of absolute access
			AM_INDIRECT: ea.addr = ea.rn;
			// Old value addresses, bumped value written later; wraps naturally
			AM_POSTINC:
			begin
				ea.addr   = ea.rn;
				ea.new_rn = ea.rn + step;
				ea.wr_rn  = 1'b1;
			end
			// Reduced value both addresses and is written back
			AM_PREDEC:
			begin
				ea.addr   = ea.rn - step;
				ea.new_rn = ea.rn - step;
				ea.wr_rn  = 1'b1;
			end
			// Wide displacement held in index register zero
			AM_INDEXED: ea.addr = ea.rn + ea.r0;
			// Literal table; longword masks the two low PC bits
			AM_PCREL:
			begin
				if (ea.size == SZ_LONG)
					ea.addr = (ea.pc & `OPAF_PC_LONG_MASK) + scaled;
				else
					ea.addr = ea.pc + scaled;
			end
			default: ea.addr = ea.rn;
		endcase
		// Byte access may sit anywhere
		ea.misalign = ea.uses_mem && (((ea.size == SZ_WORD) && ea.addr[0]) ||
		              ((ea.size == SZ_LONG) && (ea.addr[1:0] != 2'b00)));
	end

endmodule

`default_nettype wire

// File: core/opaf_core.sv
// Operand address and compare flag logic of the processor core.
// Assumes the decoder presents one operation at a time with register values,
// and that the memory port acknowledges each access with a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
`include "opaf_map.svh"

module opaf_core
	import opaf_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// Issue from the decoder
	input  wire logic        iss_valid,
	output logic             iss_ready,
	input  wire opaf_op_t    iss_op,
	input  wire opaf_mode_t  iss_mode,
	input  wire opaf_size_t  iss_size,
	input  wire logic        iss_store,
	input  wire logic [7:0]  iss_imm,
	input  wire logic [3:0]  iss_dst,
	input  wire logic [3:0]  iss_base,
	// Register file read values
	input  wire logic [31:0] rn_val,
	input  wire logic [31:0] rm_val,
	input  wire logic [31:0] r0_val,
	input  wire logic [31:0] pc_val,
	// Data memory port
	output logic             mem_req,
	output logic             mem_we,
	output logic [31:0]      mem_addr,
	output opaf_size_t       mem_size,
	output logic [31:0]      mem_wdata,
	input  wire logic        mem_ack,
	input  wire logic [31:0] mem_rdata,
	input  wire logic        insn_cancel,
	// Register file write ports
	output logic             wb_valid,
	output logic [3:0]       wb_idx,
	output logic [31:0]      wb_data,
	output logic             am_valid,
	output logic [3:0]       am_idx,
	output logic [31:0]      am_data,
	// Flag, branch and error
	output logic             cmp_flag,
	output logic             br_taken,
	output logic             addr_err
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		opaf_state_t st;        // Sequencer state
		logic        flag;      // Compare flag
		logic        mem_req;   // Access outstanding
		logic        mem_we;    // Access is a store
		logic [31:0] mem_addr;  // Access address
		opaf_size_t  mem_size;  // Access width
		logic [31:0] mem_wdata; // Store data
		logic        wb_valid;  // Destination write pulse
		logic [3:0]  wb_idx;    // Destination register
		logic [31:0] wb_data;   // Destination value
		logic        am_valid;  // Auto-modify write pulse
		logic [3:0]  am_idx;    // Auto-modified register
		logic [31:0] am_data;   // Value held until completion
		logic        pend_am;   // Auto-modify waits for completion
		logic        br_taken;  // Branch decision pulse
		logic        addr_err;  // Address error pulse
	} opaf_regs_t;

	opaf_regs_t  r;       // Registered state
	opaf_regs_t  next_r;  // Next state
	logic        take;    // Issue accepted this cycle
	logic [31:0] imm_sx;  // Sign-extended byte immediate

	opaf_ea_if ea_bus ();

	// Address unit sees the issue fields directly
	assign ea_bus.mode = (iss_op == OP_MEM) ? iss_mode : AM_DIRECT;
	assign ea_bus.size = iss_size;
	assign ea_bus.rn   = rn_val;
	assign ea_bus.r0   = r0_val;
	assign ea_bus.pc   = pc_val;
	assign ea_bus.disp = iss_imm;

	opaf_ea u_ea (
		.ea (ea_bus)
	);

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb
	begin
		next_r          = r;
		next_r.wb_valid = 1'b0;
		next_r.am_valid = 1'b0;
		next_r.br_taken = 1'b0;
		next_r.addr_err = 1'b0;
		iss_ready       = (r.st == ST_IDLE);
		take            = iss_valid && iss_ready;
		// Byte immediate taken from the instruction, no fetch
		imm_sx          = {{24{iss_imm[7]}}, iss_imm};
		unique case (r.st)
			ST_IDLE:
			begin
				if (take)
				begin
					unique case (iss_op)
						// Additions leave the flag alone
						OP_ADD_REG, OP_ADD_IMM:
						begin
							next_r.wb_valid = 1'b1;
							next_r.wb_idx   = iss_dst;
							next_r.wb_data  = rn_val + ((iss_op == OP_ADD_IMM) ? imm_sx : rm_val);
						end
						OP_COMPARE_EQUAL_IMM: next_r.flag = (r0_val == imm_sx);
						OP_COMPARE_SIGNED_NOT_LESS: next_r.flag = ($signed(rn_val) >= $signed(rm_val));
						OP_BR_SET: next_r.br_taken = r.flag;
						OP_BR_CLR: next_r.br_taken = !r.flag;
						OP_MEM:
						begin
							if (!ea_bus.uses_mem)
							begin
								// Register direct: plain register move
								next_r.wb_valid = 1'b1;
								next_r.wb_idx   = iss_dst;
								next_r.wb_data  = rm_val;
							end
							else if (ea_bus.misalign)
								next_r.addr_err = 1'b1;
							else
							begin
								// Modified register is held back until the access ends
								next_r.st        = ST_WAIT;
								next_r.mem_req   = 1'b1;
								next_r.mem_we    = iss_store && (iss_mode != AM_PCREL);
								next_r.mem_addr  = ea_bus.addr;
								next_r.mem_size  = iss_size;
								next_r.mem_wdata = rm_val;
								next_r.wb_idx    = iss_dst;
								next_r.pend_am   = ea_bus.wr_rn;
								next_r.am_idx    = iss_base;
								next_r.am_data   = ea_bus.new_rn;
							end
						end
						default: next_r.st = ST_IDLE;
					endcase
				end
			end
			ST_WAIT:
			begin
				if (insn_cancel)
				begin
					// Abandoned instruction writes nothing back
					next_r.st      = ST_IDLE;
					next_r.mem_req = 1'b0;
					next_r.pend_am = 1'b0;
				end
				else if (mem_ack)
				begin
					next_r.st       = ST_IDLE;
					next_r.mem_req  = 1'b0;
					next_r.wb_valid = !r.mem_we;
					next_r.wb_data  = opaf_sext(mem_rdata, r.mem_size);
					next_r.am_valid = r.pend_am;
					next_r.pend_am  = 1'b0;
				end
			end
		endcase
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			r      <= '0;
			r.st   <= ST_IDLE;
			r.flag <= `OPAF_FLAG_RST;
		end
		else
			r <= next_r;
	end

	// Outputs straight from flip-flops
	assign mem_req   = r.mem_req;
	assign mem_we    = r.mem_we;
	assign mem_addr  = r.mem_addr;
	assign mem_size  = r.mem_size;
	assign mem_wdata = r.mem_wdata;
	assign wb_valid  = r.wb_valid;
	assign wb_idx    = r.wb_idx;
	assign wb_data   = r.wb_data;
	assign am_valid  = r.am_valid;
	assign am_idx    = r.am_idx;
	assign am_data   = r.am_data;
	assign cmp_flag  = r.flag;
	assign br_taken  = r.br_taken;
	assign addr_err  = r.addr_err;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	property p_add_keeps_flag;
		take && (iss_op inside {OP_ADD_REG, OP_ADD_IMM}) |=> cmp_flag == $past(cmp_flag);
	endproperty
	a_add_keeps_flag: assert property (p_add_keeps_flag) else $error("flag changed by add");

	property p_compare_equal;
		take && iss_op == OP_COMPARE_EQUAL_IMM |=> cmp_flag == ($past(r0_val) == {{24{$past(iss_imm[7])}}, $past(iss_imm)});
	endproperty
	a_compare_equal: assert property (p_compare_equal) else $error("equal compare flag wrong");

	property p_compare_signed_not_less;
		take && iss_op == OP_COMPARE_SIGNED_NOT_LESS |=> cmp_flag == ($signed($past(rn_val)) >= $signed($past(rm_val)));
	endproperty
	a_compare_signed_not_less: assert property (p_compare_signed_not_less) else $error("signed compare flag wrong");

	property p_branch;
		take && iss_op inside {OP_BR_SET, OP_BR_CLR}
		|=> br_taken == ($past(cmp_flag) ^ ($past(iss_op) == OP_BR_CLR));
	endproperty
	a_branch: assert property (p_branch) else $error("branch decision wrong");

	property p_direct;
		take && iss_op == OP_MEM && iss_mode == AM_DIRECT
		|=> !mem_req && wb_valid && wb_data == $past(rm_val);
	endproperty
	a_direct: assert property (p_direct) else $error("direct mode touched memory");

	property p_indirect;
		take && iss_op == OP_MEM && iss_mode == AM_INDIRECT && !ea_bus.misalign
		|=> mem_req && mem_addr == $past(rn_val) && !am_valid;
	endproperty
	a_indirect: assert property (p_indirect) else $error("indirect address wrong");

	property p_postinc;
		take && iss_op == OP_MEM && iss_mode == AM_POSTINC && !ea_bus.misalign
		|=> mem_addr == $past(rn_val) && am_data == $past(rn_val) + opaf_step($past(iss_size));
	endproperty
	a_postinc: assert property (p_postinc) else $error("post-increment wrong");

	property p_predec;
		take && iss_op == OP_MEM && iss_mode == AM_PREDEC && !ea_bus.misalign
		|=> mem_addr == $past(rn_val) - opaf_step($past(iss_size)) && am_data == mem_addr;
	endproperty
	a_predec: assert property (p_predec) else $error("pre-decrement wrong");

	property p_misalign;
		take && iss_op == OP_MEM && ea_bus.misalign |=> addr_err && !mem_req ##1 !addr_err;
	endproperty
	a_misalign: assert property (p_misalign) else $error("address error missing");

	property p_lit_long;
		take && iss_op == OP_MEM && iss_mode == AM_PCREL && iss_size == SZ_LONG
		|=> mem_addr == (($past(pc_val) & `OPAF_PC_LONG_MASK) + {22'h0, $past(iss_imm), 2'b00});
	endproperty
	a_lit_long: assert property (p_lit_long) else $error("longword literal address wrong");

	property p_sext_byte;
		r.st == ST_WAIT && mem_ack && !insn_cancel && !mem_we && mem_size == SZ_BYTE
		|=> wb_valid && wb_data == {{24{$past(mem_rdata[7])}}, $past(mem_rdata[7:0])};
	endproperty
	a_sext_byte: assert property (p_sext_byte) else $error("byte load not sign-extended");

	property p_cancel;
		r.st == ST_WAIT && insn_cancel |=> !am_valid && !wb_valid ##1 !am_valid;
	endproperty
	a_cancel: assert property (p_cancel) else $error("cancelled instruction wrote back");

	// Main scenarios
	c_cmp_then_branch: cover property (take && iss_op == OP_COMPARE_EQUAL_IMM ##1 take && iss_op == OP_BR_SET);
	c_postinc_done: cover property (am_valid && wb_valid);
	c_literal_load: cover property (take && iss_mode == AM_PCREL && iss_op == OP_MEM ##[1:20] wb_valid);
	c_addr_err: cover property (addr_err);

endmodule

`default_nettype wire

// File: test/test_opaf_core.sv
// Self-checking bench for opaf_core: compare flag, branches and operand addressing.
// Assumes opaf_pkg is compiled first; the bench plays decoder, register file and memory.
`timescale 1ns/1ps
`default_nettype none

module test_opaf_core
	import opaf_pkg::*;
;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic             clk;         // 25 MHz core clock
	logic             sys_rst;     // Synchronous reset
	logic             iss_valid;   // Decoder issue
	logic             iss_ready;   // Core idle
	opaf_op_t         iss_op;      // Operation class
	opaf_mode_t       iss_mode;    // Addressing mode
	opaf_size_t       iss_size;    // Operand size
	logic             iss_store;   // Store flag
	logic [7:0]       iss_imm;     // Immediate or displacement
	logic [3:0]       iss_dst;     // Destination index
	logic [3:0]       iss_base;    // Auto-modified index
	logic [31:0]      rn_val;      // Register values
	logic [31:0]      rm_val;
	logic [31:0]      r0_val;
	logic [31:0]      pc_val;
	logic             mem_req;     // Memory port
	logic             mem_we;
	logic [31:0]      mem_addr;
	opaf_size_t       mem_size;
	logic [31:0]      mem_wdata;
	logic             mem_ack;
	logic [31:0]      mem_rdata;
	logic             insn_cancel; // Abort of the waiting instruction
	logic             wb_valid;    // Write ports
	logic [3:0]       wb_idx;
	logic [31:0]      wb_data;
	logic             am_valid;
	logic [3:0]       am_idx;
	logic [31:0]      am_data;
	logic             cmp_flag;    // Flag, branch, error
	logic             br_taken;
	logic             addr_err;
	int               fail_count;  // Mismatches
	int               check_count; // Comparisons

	opaf_core dut (.clk(clk), .sys_rst(sys_rst), .iss_valid(iss_valid), .iss_ready(iss_ready),
		.iss_op(iss_op), .iss_mode(iss_mode), .iss_size(iss_size), .iss_store(iss_store),
		.iss_imm(iss_imm), .iss_dst(iss_dst), .iss_base(iss_base), .rn_val(rn_val),
		.rm_val(rm_val), .r0_val(r0_val), .pc_val(pc_val), .mem_req(mem_req), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_size(mem_size), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata), .insn_cancel(insn_cancel), .wb_valid(wb_valid), .wb_idx(wb_idx),
		.wb_data(wb_data), .am_valid(am_valid), .am_idx(am_idx), .am_data(am_data),
		.cmp_flag(cmp_flag), .br_taken(br_taken), .addr_err(addr_err));

	// Free-running clock, 40 ns period
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ------------------------------------------------------------
	// Compare, issue and memory tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp, input string what);
		check_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("BAD t=%0t %s got %b exp %b", $time, what, got, exp);
		end
	endtask

	// One issue; returns 1 ns after the taken edge, when results have landed
	task automatic issue(input opaf_op_t op, input opaf_mode_t md, input opaf_size_t sz, input logic st,
		input logic [7:0] imm, input logic [31:0] rn, input logic [31:0] r0, input logic [31:0] pc);
		@(posedge clk);
		iss_valid <= 1'b1;
		iss_op    <= op;
		iss_mode  <= md;
		iss_size  <= sz;
		iss_store <= st;
		iss_imm   <= imm;
		rn_val    <= rn;
		r0_val    <= r0;
		pc_val    <= pc;
		#1;
		chk1(iss_ready, 1'b1, "ready before issue");
		@(posedge clk);
		// Register values go stale right away: the core must have sampled them
		iss_valid <= 1'b0;
		iss_op    <= OP_NONE;
		rn_val    <= ~rn;
		r0_val    <= ~r0;
		pc_val    <= ~pc;
		#1;
	endtask

	// Memory operation, held one slow cycle, then acknowledged or cancelled
	task automatic mem_op(input opaf_mode_t md, input opaf_size_t sz, input logic st, input logic [7:0] imm,
		input logic [31:0] rn, input logic [31:0] r0, input logic [31:0] pc, input logic [31:0] ea,
		input logic [31:0] rd, input logic [31:0] wbd, input logic amv, input logic [31:0] amd,
		input logic cancel);
		issue(OP_MEM, md, sz, st, imm, rn, r0, pc);
		chk1(mem_req, 1'b1, "request raised");
		chk(mem_addr, ea, "address");
		chk({30'h0, mem_size}, {30'h0, sz}, "access size");
		chk1(mem_we, st, "write flag");
		if (st)
			chk(mem_wdata, rm_val, "store data");
		@(posedge clk);
		mem_ack     <= ~cancel;
		insn_cancel <= cancel;
		mem_rdata   <= rd;
		#1;
		chk1(mem_req, 1'b1, "request stands");
		chk1(iss_ready, 1'b0, "busy while waiting");
		@(posedge clk);
		mem_ack     <= 1'b0;
		insn_cancel <= 1'b0;
		mem_rdata   <= ~rd;
		#1;
		chk1(mem_req, 1'b0, "request released");
		chk1(wb_valid, ~st & ~cancel, "load write-back");
		if (!st && !cancel)
		begin
			chk(wb_data, wbd, "loaded value");
			chk({28'h0, wb_idx}, 32'h00000003, "load index");
		end
		chk1(am_valid, amv & ~cancel, "auto-modify write");
		if (amv && !cancel)
		begin
			chk(am_data, amd, "auto-modified value");
			chk({28'h0, am_idx}, 32'h00000005, "auto-modify index");
		end
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_flag();
		issue(OP_COMPARE_EQUAL_IMM, AM_DIRECT, SZ_LONG, 1'b0, 8'h00, 32'h0, 32'h00000000, 32'h0);
		chk1(cmp_flag, 1'b1, "equal to zero");
		issue(OP_ADD_IMM, AM_DIRECT, SZ_LONG, 1'b0, 8'h01, 32'h0, 32'h00000001, 32'h0);
		chk1(cmp_flag, 1'b1, "immediate add keeps flag");
		chk(wb_data, 32'h00000001, "immediate add sum");
		issue(OP_BR_SET, AM_DIRECT, SZ_LONG, 1'b0, 8'h00, 32'h0, 32'h0, 32'h0);
		chk1(br_taken, 1'b1, "branch on set");
		issue(OP_COMPARE_EQUAL_IMM, AM_DIRECT, SZ_LONG, 1'b0, 8'h00, 32'h0, 32'h00000001, 32'h0);
		chk1(cmp_flag, 1'b0, "not equal");
		issue(OP_ADD_REG, AM_DIRECT, SZ_LONG, 1'b0, 8'h00, 32'h0, 32'h0, 32'h0);
		chk1(cmp_flag, 1'b0, "register add keeps flag");
		issue(OP_BR_SET, AM_DIRECT, SZ_LONG, 1'b0, 8'h00, 32'h0, 32'h0, 32'h0);
		chk1(br_taken, 1'b0, "no branch on clear flag");
		issue(OP_COMPARE_EQUAL_IMM, AM_DIRECT, SZ_LONG, 1'b0, 8'hFF, 32'h0, 32'hFFFFFFFF, 32'h0);
		chk1(cmp_flag, 1'b1, "byte immediate from instruction");
		$display("done: flag and branches");
	endtask

	task automatic t_ge();
		@(posedge clk) rm_val <= 32'h00000001;
		issue(OP_COMPARE_SIGNED_NOT_LESS, AM_DIRECT, SZ_LONG, 1'b0, 8'h00, 32'hFFFFFFFF, 32'h0, 32'h0);
		chk1(cmp_flag, 1'b0, "negative below one");
		issue(OP_BR_CLR, AM_DIRECT, SZ_LONG, 1'b0, 8'h00, 32'h0, 32'h0, 32'h0);
		chk1(br_taken, 1'b1, "branch on clear");
		@(posedge clk) rm_val <= 32'h80000000;
		issue(OP_COMPARE_SIGNED_NOT_LESS, AM_DIRECT, SZ_LONG, 1'b0, 8'h00, 32'h00000001, 32'h0, 32'h0);
		chk1(cmp_flag, 1'b1, "above most negative");
		@(posedge clk) rm_val <= 32'h00000005;
		issue(OP_COMPARE_SIGNED_NOT_LESS, AM_DIRECT, SZ_LONG, 1'b0, 8'h00, 32'h00000005, 32'h0, 32'h0);
		chk1(cmp_flag, 1'b1, "equal counts as not less");
		issue(OP_BR_CLR, AM_DIRECT, SZ_LONG, 1'b0, 8'h00, 32'h0, 32'h0, 32'h0);
		chk1(br_taken, 1'b0, "no branch on set");
		$display("done: signed compare");
	endtask

	// Every auto-modify mode against every size; looped byte and word loads see negative data
	task automatic t_modes();
		opaf_mode_t  md;
		opaf_size_t  sz;
		logic [31:0] st;
		logic [31:0] wbd;
		for (int m = 0; m < 3; m++)
			for (int s = 0; s < 3; s++)
			begin
				md  = (m == 0) ? AM_INDIRECT : (m == 1) ? AM_POSTINC : AM_PREDEC;
				sz  = opaf_size_t'(s);
				st  = (s == 0) ? 32'h00000001 : (s == 1) ? 32'h00000002 : 32'h00000004;
				wbd = (s == 0) ? 32'hFFFFFF81 : (s == 1) ? 32'hFFFF8081 : 32'h7FFF8081;
				mem_op(md, sz, 1'b0, 8'h00, 32'h00001000, 32'h0, 32'h0, (m == 2) ? 32'h00001000 - st : 32'h00001000,
					32'h7FFF8081, wbd, m != 0, (m == 1) ? 32'h00001000 + st : 32'h00001000 - st, 1'b0);
			end
		mem_op(AM_POSTINC, SZ_LONG, 1'b1, 8'h00, 32'hFFFFFFFC, 32'h0, 32'h0, 32'hFFFFFFFC,
			32'h0, 32'h0, 1'b1, 32'h00000000, 1'b0);
		mem_op(AM_PREDEC, SZ_BYTE, 1'b0, 8'h00, 32'h00000000, 32'h0, 32'h0, 32'hFFFFFFFF,
			32'h0000007F, 32'h0000007F, 1'b1, 32'hFFFFFFFF, 1'b0);
		$display("done: auto-modify modes");
	endtask

	task automatic t_errors();
		issue(OP_MEM, AM_DIRECT, SZ_LONG, 1'b0, 8'h00, 32'h00001000, 32'h0, 32'h0);
		chk1(mem_req, 1'b0, "direct has no access");
		chk1(wb_valid, 1'b1, "direct write-back");
		chk(wb_data, 32'h00000005, "direct operand is register");
		issue(OP_MEM, AM_INDIRECT, SZ_WORD, 1'b0, 8'h00, 32'h00001001, 32'h0, 32'h0);
		chk1(addr_err, 1'b1, "odd word address");
		chk1(mem_req, 1'b0, "no access on error");
		issue(OP_MEM, AM_POSTINC, SZ_LONG, 1'b0, 8'h00, 32'h00001002, 32'h0, 32'h0);
		chk1(addr_err, 1'b1, "longword off four");
		chk1(am_valid, 1'b0, "no modify on error");
		mem_op(AM_POSTINC, SZ_WORD, 1'b0, 8'h00, 32'h00001002, 32'h0, 32'h0, 32'h00001002,
			32'h0, 32'h0, 1'b1, 32'h0, 1'b1);
		$display("done: errors and cancel");
	endtask

	// Literal loads, then absolute and wide displacement second steps
	task automatic t_literal();
		mem_op(AM_PCREL, SZ_LONG, 1'b0, 8'h10, 32'h0, 32'h0, 32'h00002006, 32'h00002044,
			32'h12345678, 32'h12345678, 1'b0, 32'h0, 1'b0);
		mem_op(AM_INDIRECT, SZ_BYTE, 1'b0, 8'h00, 32'h12345678, 32'h0, 32'h0, 32'h12345678,
			32'h00000042, 32'h00000042, 1'b0, 32'h0, 1'b0);
		mem_op(AM_PCREL, SZ_WORD, 1'b0, 8'h81, 32'h0, 32'h0, 32'h00002006, 32'h00002108,
			32'hABCD1234, 32'h00001234, 1'b0, 32'h0, 1'b0);
		mem_op(AM_PCREL, SZ_BYTE, 1'b0, 8'h05, 32'h0, 32'h0, 32'h00002006, 32'h0000200B,
			32'h000000F0, 32'hFFFFFFF0, 1'b0, 32'h0, 1'b0);
		mem_op(AM_INDEXED, SZ_WORD, 1'b0, 8'h00, 32'h00000100, 32'h00001234, 32'h0, 32'h00001334,
			32'h0000F000, 32'hFFFFF000, 1'b0, 32'h0, 1'b0);
		$display("done: literal table access");
	endtask

	// ------------------------------------------------------------
	// Run control
	// ------------------------------------------------------------
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial
	begin
		fail_count = 0;
		check_count = 0;
		{iss_valid, iss_store, mem_ack, insn_cancel} = 4'h0;
		iss_op = OP_NONE;
		iss_mode = AM_DIRECT;
		iss_size = SZ_LONG;
		iss_imm = 8'h00;
		iss_dst = 4'h3;
		iss_base = 4'h5;
		{rn_val, rm_val, r0_val, pc_val, mem_rdata} = {5{32'h0}};
		sys_rst = 1'b1;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		#1;
		chk1(cmp_flag, 1'b0, "flag after reset");
		chk1(iss_ready, 1'b1, "ready after reset");
		t_flag();
		t_ge();
		t_modes();
		t_errors();
		t_literal();
		stop_test();
	end

	// Watchdog: the whole run needs well under 1000 cycles
	initial
	begin
		repeat (5000) @(posedge clk);
		fail_count++;
		$display("BAD t=%0t run hung", $time);
		stop_test();
	end
endmodule

`default_nettype wire
